/* File: logic/frrmw_defines.svh */
// constants for the file-register operand decoder and read-modify-write unit
// assumes a 14-bit instruction word and an 8-bit data path
`ifndef FRRMW_DEFINES_SVH
`define FRRMW_DEFINES_SVH
`define FRRMW_IW_W       14
`define FRRMW_FADDR_LSB  0
`define FRRMW_FADDR_W    7
`define FRRMW_DEST_BIT   7
`define FRRMW_BSEL_LSB   7
`define FRRMW_BSEL_W     3
`define FRRMW_K8_W       8
`define FRRMW_K11_W      11
`define FRRMW_FADDR_MAX  7'h7F
`define FRRMW_OSC_PER_IC 4
`define FRRMW_RST_W      8'h00
`define FRRMW_C_BIT      0
`define FRRMW_DC_BIT     1
`define FRRMW_Z_BIT      2
`define FRRMW_PORT_A_DATA_REG_ADDR 7'h05
`endif

/* File: logic/frrmw_pkg.sv */
// types shared by the read-modify-write unit and its operation decoder
// assumes frrmw_defines.svh is on the include path
package frrmw_pkg;
  // operation classes picked out of the opcode
  typedef enum logic [3:0] {
    FRRMW_OP_NOP, FRRMW_OP_ADD, FRRMW_OP_AND, FRRMW_OP_CLR, FRRMW_OP_MOVF,
    FRRMW_OP_MOVWF, FRRMW_OP_BCF, FRRMW_OP_BSF, FRRMW_OP_BTFSC,
    FRRMW_OP_BTFSS, FRRMW_OP_MOVLW, FRRMW_OP_GOTO
  } frrmw_op_t;
  typedef enum logic [1:0] {
    FRRMW_ST_FETCH, FRRMW_ST_READ, FRRMW_ST_WRITE, FRRMW_ST_NOP
  } frrmw_state_t;
endpackage

/* File: logic/frrmw_opdec.sv */
// combinational opcode classifier for the 14-bit instruction word
// assumes the word is stable from the same clock domain
`timescale 1ns/1ps
`include "frrmw_defines.svh"
module frrmw_opdec
  import frrmw_pkg::*;
(
  input  wire logic [13:0]         instr_i,
  output frrmw_pkg::frrmw_op_t     op_o,
  output logic                     uses_file_o,
  output logic [2:0]               flag_mask_o
);
  // only opcode bits are examined; operand and don't-care bits never are
  always_comb
  begin
    op_o        = FRRMW_OP_NOP;
    flag_mask_o = 3'h0;
    casez (instr_i)
      14'b00_0111_????_????: begin op_o = FRRMW_OP_ADD;  flag_mask_o = 3'h7; end
      14'b00_0101_????_????: begin op_o = FRRMW_OP_AND;  flag_mask_o = 3'h4; end
      14'b00_0001_1???_????: begin op_o = FRRMW_OP_CLR;  flag_mask_o = 3'h4; end
      14'b00_1000_????_????: begin op_o = FRRMW_OP_MOVF; flag_mask_o = 3'h4; end
      14'b00_0000_1???_????: op_o = FRRMW_OP_MOVWF;
      14'b01_00??_????_????: op_o = FRRMW_OP_BCF;
      14'b01_01??_????_????: op_o = FRRMW_OP_BSF;
      14'b01_10??_????_????: op_o = FRRMW_OP_BTFSC;
      14'b01_11??_????_????: op_o = FRRMW_OP_BTFSS;
      14'b11_00??_????_????: op_o = FRRMW_OP_MOVLW; // low two x bits ignored
      14'b10_1???_????_????: op_o = FRRMW_OP_GOTO;
      default:               op_o = FRRMW_OP_NOP;
    endcase
    uses_file_o = (op_o != FRRMW_OP_NOP) && (op_o != FRRMW_OP_MOVLW)
                  && (op_o != FRRMW_OP_GOTO);
  end
endmodule // frrmw_opdec

/* File: logic/frrmw_core.sv */
// read-modify-write execution unit for file-register instructions
// assumes a synchronous single-cycle data memory on the same clock
`timescale 1ns/1ps
`include "frrmw_defines.svh"
// Contract
// - a file-register instruction runs as read, modify, then store.
// - the register is read even when the instruction only writes it.
// - the implied read of port A clears the port change mismatch.
// - destination bit 0 stores to the accumulator, 1 to the register.
// - the address field picks one of 0x00 to 0x7F in the active bank.
// - the bit field picks one bit of the 8-bit register for bit ops.
// - don't-care bits of the word have no effect on behaviour.
// - the literal is used directly with no memory access.
// - instructions are 14-bit words with 8- or 11-bit literals.
// - an instruction takes one cycle, two when a skip or jump occurs; here file-register ops take three cycles (four on a skip).
module frrmw_core
  import frrmw_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        instr_valid_i,
  input  wire logic [13:0] instr_i,
  input  wire logic [7:0]  mem_rdata_i,
  output logic             instr_ready_o,
  output logic             mem_re_o,
  output logic             mem_we_o,
  output logic [6:0]       mem_addr_o,
  output logic [7:0]       mem_wdata_o,
  output logic             port_a_data_reg_mismatch_clr_o,
  output logic [7:0]       w_o,
  output logic [2:0]       flags_o,
  output logic             pc_load_o,
  output logic [10:0]      pc_target_o,
  output logic             skip_o
);
  import frrmw_pkg::*;

  // ***********************************************
  // state record
  // ***********************************************
  typedef struct packed {
    frrmw_state_t st;
    logic [13:0]  ir;
    frrmw_op_t    op;
    logic [2:0]   fmask;
    logic         rdy;
    logic         re;
    logic         we;
    logic [6:0]   addr;
    logic [7:0]   wdata;
    logic         pclr;
    logic [7:0]   w;
    logic [2:0]   flags;
    logic         pcl;
    logic [10:0]  pct;
    logic         skip;
  } frrmw_regs_t;

  frrmw_regs_t r;
  frrmw_regs_t next_r;
  frrmw_op_t   dec_op;
  logic        dec_file;
  logic [2:0]  dec_mask;

  frrmw_opdec u_dec (
    .instr_i     (instr_i),
    .op_o        (dec_op),
    .uses_file_o (dec_file),
    .flag_mask_o (dec_mask)
  );

  // ***********************************************
  // operand fields
  // ***********************************************
  logic [6:0]  f_addr;
  logic        dest_f;
  logic [2:0]  bsel;
  logic [7:0]  bmask;
  logic [8:0]  sum;
  logic [4:0]  nsum;
  logic [7:0]  res;
  logic        bitv;
  assign f_addr = r.ir[6:0];
  assign dest_f = r.ir[`FRRMW_DEST_BIT];
  assign bsel   = r.ir[9:7];
  assign bmask  = 8'h01 << bsel;
  assign bitv   = |(mem_rdata_i & bmask);
  assign sum    = {1'b0, mem_rdata_i} + {1'b0, r.w};
  assign nsum   = {1'b0, mem_rdata_i[3:0]} + {1'b0, r.w[3:0]};

  // modify stage: compute the result from the value just read
  always_comb
  begin
    res = mem_rdata_i;
    case (r.op)
      FRRMW_OP_ADD:   res = sum[7:0];
      FRRMW_OP_AND:   res = mem_rdata_i & r.w;
      FRRMW_OP_CLR:   res = 8'h00;   // read still happened first
      FRRMW_OP_MOVWF: res = r.w;
      FRRMW_OP_BCF:   res = mem_rdata_i & ~bmask;
      FRRMW_OP_BSF:   res = mem_rdata_i | bmask;
      default:        res = mem_rdata_i;
    endcase
  end

  // ***********************************************
  // sequencer
  // ***********************************************
  // read strobe goes out in READ; the synchronous memory answers a cycle
  // later, so the modify happens in WRITE, never on stale data, and the store strobe goes out the cycle after
  always_comb
  begin
    next_r      = r;
    next_r.re   = 1'b0;
    next_r.we   = 1'b0;
    next_r.pclr = 1'b0;
    next_r.pcl  = 1'b0;
    next_r.skip = 1'b0;
    case (r.st)
      FRRMW_ST_FETCH:
      begin
        next_r.rdy = 1'b1;
        if (instr_valid_i && r.rdy)
        begin
          next_r.ir    = instr_i;
          next_r.op    = dec_op;
          next_r.fmask = dec_mask;
          next_r.rdy   = 1'b0;
          if (dec_file)
          begin
            next_r.st   = FRRMW_ST_READ;
            next_r.re   = 1'b1;
            next_r.addr = instr_i[6:0];
            next_r.pclr = (instr_i[6:0] == `FRRMW_PORT_A_DATA_REG_ADDR);
          end
          else if (dec_op == FRRMW_OP_MOVLW)
          begin
            next_r.w   = instr_i[7:0];
            next_r.rdy = 1'b1;
          end
          else if (dec_op == FRRMW_OP_GOTO)
          begin
            next_r.pcl = 1'b1;
            next_r.pct = instr_i[10:0];
            next_r.st  = FRRMW_ST_NOP;
          end
          else
            next_r.rdy = 1'b1;
        end
      end
      FRRMW_ST_READ:
      begin
        next_r.st = FRRMW_ST_WRITE;
      end
      FRRMW_ST_WRITE:
      begin
        next_r.st  = FRRMW_ST_FETCH;
        next_r.rdy = 1'b1;
        if (r.fmask[2])
          next_r.flags[`FRRMW_Z_BIT] = (res == 8'h00);
        if (r.fmask[0])
          next_r.flags[`FRRMW_C_BIT] = sum[8];
        if (r.fmask[1])
          next_r.flags[`FRRMW_DC_BIT] = nsum[4];
        case (r.op)
          FRRMW_OP_BTFSC, FRRMW_OP_BTFSS:
          begin
            // a true test costs a second, empty cycle
            if (bitv == (r.op == FRRMW_OP_BTFSS))
            begin
              next_r.skip = 1'b1;
              next_r.st   = FRRMW_ST_NOP;
              next_r.rdy  = 1'b0;
            end
            else
            begin
              next_r.st  = FRRMW_ST_FETCH;
              next_r.rdy = 1'b1;
            end
          end
          FRRMW_OP_MOVWF, FRRMW_OP_CLR, FRRMW_OP_BCF, FRRMW_OP_BSF:
          begin
            next_r.we    = 1'b1;
            next_r.wdata = res;
          end
          default:
          begin
            if (dest_f)
            begin
              next_r.we    = 1'b1;
              next_r.wdata = res;
            end
            else
              next_r.w = res;
          end
        endcase
        next_r.addr = f_addr;
      end
      FRRMW_ST_NOP:
      begin
        next_r.st  = FRRMW_ST_FETCH;
        next_r.rdy = 1'b1;
      end
      default: next_r.st = FRRMW_ST_FETCH;
    endcase
  end

  // register the whole record
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      r       <= '0;
      r.st    <= FRRMW_ST_FETCH;
      r.op    <= FRRMW_OP_NOP;
      r.w     <= `FRRMW_RST_W;
    end
    else
      r <= next_r;
  end

  assign instr_ready_o        = r.rdy;
  assign mem_re_o             = r.re;
  assign mem_we_o             = r.we;
  assign mem_addr_o           = r.addr;
  assign mem_wdata_o          = r.wdata;
  assign port_a_data_reg_mismatch_clr_o = r.pclr;
  assign w_o                  = r.w;
  assign flags_o              = r.flags;
  assign pc_load_o            = r.pcl;
  assign pc_target_o          = r.pct;
  assign skip_o               = r.skip;

  // ***********************************************
  // checks
  // ***********************************************
  AST_READ_BEFORE_WRITE: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) mem_we_o |-> $past(mem_re_o, 2))
    else $error("write without preceding read");
  AST_PORT_A_DATA_REG_CLR: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (mem_re_o && mem_addr_o == 7'h05) |-> port_a_data_reg_mismatch_clr_o)
    else $error("port a read did not clear mismatch");
  AST_DEST_W: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (r.st == FRRMW_ST_WRITE && r.op == FRRMW_OP_ADD && !dest_f)
    |=> !mem_we_o)
    else $error("d=0 wrote the file register");
  AST_DEST_F: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (r.st == FRRMW_ST_WRITE && r.op == FRRMW_OP_ADD && dest_f)
    |=> mem_we_o && mem_addr_o == $past(f_addr))
    else $error("d=1 did not store to f");
  AST_CLR_ZERO: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (r.st == FRRMW_ST_WRITE && r.op == FRRMW_OP_CLR)
    |=> flags_o[2] && mem_wdata_o == 8'h00)
    else $error("clear did not set zero");
  AST_GOTO_TWO: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) pc_load_o |-> !instr_ready_o ##1 instr_ready_o)
    else $error("jump not two cycles");
  AST_LIT_NOMEM: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (r.rdy && instr_valid_i && dec_op == FRRMW_OP_MOVLW)
    |=> !mem_re_o && w_o == $past(instr_i[7:0]))
    else $error("literal touched memory");
  AST_FLAGS_KEPT: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (r.st == FRRMW_ST_WRITE && r.fmask == 3'h0) |=> $stable(flags_o))
    else $error("flags changed without cause");
  AST_ADDR_RANGE: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) mem_re_o |-> mem_addr_o == $past(instr_i[6:0]))
    else $error("wrong file address");
endmodule // frrmw_core

/* File: bench/tb_file_register_operand_decode_rmw.sv */
// self-checking bench for the read-modify-write unit, random and corner ops
// assumes frrmw_defines.svh on the include path and the designer's walk
`timescale 1ns/1ps
`include "frrmw_defines.svh"
module tb_file_register_operand_decode_rmw;
  localparam int  DLY   = 1;    // input skew after each rising edge
  localparam int  LIMIT = 2000; // cycle ceiling, ops need a few hundred
  localparam logic [5:0] OP_ADD = 6'h07;
  localparam logic [5:0] OP_AND = 6'h05;
  logic        ref_clk_i;
  logic        sys_rst_i;
  logic        instr_valid_i;
  logic [13:0] instr_i;
  logic [7:0]  mem_rdata_i;
  logic        instr_ready_o;
  logic        mem_re_o;
  logic        mem_we_o;
  logic [6:0]  mem_addr_o;
  logic [7:0]  mem_wdata_o;
  logic        port_a_data_reg_mismatch_clr_o;
  logic [7:0]  w_o;
  logic [2:0]  flags_o;
  logic        pc_load_o;
  logic [10:0] pc_target_o;
  logic        skip_o;
  int          err_count;
  int          tests_run;
  int          cyc;
  logic [31:0] rng;
  logic [7:0]  w_m;   // expected accumulator
  logic [2:0]  flg_m; // expected {Z,DC,C}
  logic [13:0] rnd_iw; // random instruction word
  frrmw_core dut (
    .ref_clk_i           (ref_clk_i),
    .sys_rst_i           (sys_rst_i),
    .instr_valid_i       (instr_valid_i),
    .instr_i             (instr_i),
    .mem_rdata_i         (mem_rdata_i),
    .instr_ready_o       (instr_ready_o),
    .mem_re_o            (mem_re_o),
    .mem_we_o            (mem_we_o),
    .mem_addr_o          (mem_addr_o),
    .mem_wdata_o         (mem_wdata_o),
    .port_a_data_reg_mismatch_clr_o(port_a_data_reg_mismatch_clr_o),
    .w_o                 (w_o),
    .flags_o             (flags_o),
    .pc_load_o           (pc_load_o),
    .pc_target_o         (pc_target_o),
    .skip_o              (skip_o)
  );
  // ********************************************************************
  // clock, hang guard and helpers
  // ********************************************************************
  initial ref_clk_i = 1'b0;
  always #25 ref_clk_i = ~ref_clk_i;
  // a hang counts as a mismatch and ends the run through the one report
  always @(posedge ref_clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == LIMIT)
    begin
      err_count = err_count + 1;
      final_report();
    end
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      err_count = err_count + 1;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ********************************************************************
  // one file-register op: take, read, data returned, store
  // ********************************************************************
  task automatic file_op(input logic [5:0] opc, input logic d,
                         input logic [6:0] f, input logic [7:0] fv);
    int          n;
    logic [8:0]  sum;
    logic [7:0]  res;
    logic [2:0]  fl;
    n = 0;
    while (instr_ready_o !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk_i);
      #DLY;
      n = n + 1;
    end
    instr_i       = {opc, d, f};
    instr_valid_i = 1'b1;
    @(posedge ref_clk_i);
    #DLY;
    // c1: a second request now must be refused while ready is low
    instr_i = {OP_ADD, ~d, ~f};
    check("re", {15'h0, mem_re_o}, 16'h1);
    check("addr", {9'h0, mem_addr_o}, {9'h0, f});
    check("pclr", {15'h0, port_a_data_reg_mismatch_clr_o},
          {15'h0, f == `FRRMW_PORT_A_DATA_REG_ADDR});
    check("rdy_c1", {15'h0, instr_ready_o}, 16'h0);
    mem_rdata_i = fv;
    @(posedge ref_clk_i);
    #DLY;
    instr_valid_i = 1'b0;
    check("re_c2", {15'h0, mem_re_o}, 16'h0);
    @(posedge ref_clk_i);
    #DLY;
    mem_rdata_i = ~fv; // read data no longer held by memory
    sum = {1'b0, w_m} + {1'b0, fv};
    if (opc == OP_ADD)
    begin
      res = sum[7:0];
      fl  = {res == 8'h00, ({1'b0, w_m[3:0]} + {1'b0, fv[3:0]}) > 5'h0F,
             sum[8]};
    end
    else
    begin
      res = w_m & fv;
      fl  = {res == 8'h00, flg_m[1:0]};
    end
    check("we", {15'h0, mem_we_o}, {15'h0, d});
    if (d)
      check("wdata", {8'h0, mem_wdata_o}, {8'h0, res});
    else
      w_m = res;
    check("w", {8'h0, w_o}, {8'h0, w_m});
    check("flags", {13'h0, flags_o}, {13'h0, fl});
    check("rdy_c3", {15'h0, instr_ready_o}, 16'h1);
    check("nojump", {14'h0, skip_o, pc_load_o}, 16'h0);
    flg_m = fl;
  endtask
  // ********************************************************************
  // other ops: clear, moves, bit ops, literal and jump
  // ********************************************************************
  task automatic misc_op(input logic [13:0] iw, input logic [7:0] fv);
    int          n;
    logic [7:0]  bm;
    logic [7:0]  res;
    logic        wr;
    logic        tst;
    n = 0;
    while (instr_ready_o !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk_i);
      #DLY;
      n = n + 1;
    end
    bm            = 8'h01 << iw[9:7];
    instr_i       = iw;
    instr_valid_i = 1'b1;
    @(posedge ref_clk_i);
    #DLY;
    instr_valid_i = 1'b0;
    if (iw[13:12] == 2'h3)
    begin
      // x bits may hold anything, only the low byte reaches w
      w_m = iw[7:0];
      check("lit_w", {8'h0, w_o}, {8'h0, w_m});
      check("lit_re", {15'h0, mem_re_o}, 16'h0);
      check("lit_rdy", {15'h0, instr_ready_o}, 16'h1);
      @(posedge ref_clk_i);
      #DLY;
    end
    else if (iw[13:12] == 2'h2)
    begin
      check("jmp_ld", {15'h0, pc_load_o}, 16'h1);
      check("jmp_pc", {5'h0, pc_target_o}, {5'h0, iw[10:0]});
      check("jmp_re", {15'h0, mem_re_o}, 16'h0);
      @(posedge ref_clk_i);
      #DLY;
      check("jmp_rdy", {15'h0, instr_ready_o}, 16'h1);
    end
    else
    begin
      check("m_re", {15'h0, mem_re_o}, 16'h1);
      check("m_addr", {9'h0, mem_addr_o}, {9'h0, iw[6:0]});
      check("m_pclr", {15'h0, port_a_data_reg_mismatch_clr_o},
            {15'h0, iw[6:0] == `FRRMW_PORT_A_DATA_REG_ADDR});
      mem_rdata_i = fv;
      repeat (2) @(posedge ref_clk_i);
      #DLY;
      mem_rdata_i = ~fv;
      wr  = 1'b1;
      res = fv;
      tst = 1'b0;
      case (iw[13:10])
        4'h0: res = iw[8] ? 8'h00 : w_m; // clear, or move w to f
        4'h2: wr = iw[7];                // move f follows d
        4'h4: res = fv & ~bm;
        4'h5: res = fv | bm;
        4'h6:
        begin
          wr  = 1'b0;
          tst = ~|(fv & bm);
        end
        default:
        begin
          wr  = 1'b0;
          tst = |(fv & bm);
        end
      endcase
      if (iw[13:10] == 4'h0 && iw[8])
        flg_m[2] = 1'b1;
      if (iw[13:10] == 4'h2)
        flg_m[2] = (fv == 8'h00);
      if (iw[13:10] == 4'h2 && !iw[7])
        w_m = fv;
      check("m_we", {15'h0, mem_we_o}, {15'h0, wr});
      if (wr)
        check("m_wdata", {8'h0, mem_wdata_o}, {8'h0, res});
      check("m_w", {8'h0, w_o}, {8'h0, w_m});
      check("m_flags", {13'h0, flags_o}, {13'h0, flg_m});
      check("m_skip", {15'h0, skip_o}, {15'h0, tst});
      check("m_rdy", {15'h0, instr_ready_o}, {15'h0, ~tst});
      if (tst)
      begin
        @(posedge ref_clk_i);
        #DLY;
        check("skip_rdy", {15'h0, instr_ready_o}, 16'h1);
      end
    end
  endtask
  // ********************************************************************
  // main sequence: reset, corner addresses, then random ops
  // ********************************************************************
  initial
  begin
    err_count     = 0;
    tests_run     = 0;
    cyc           = 0;
    rng           = 32'h00008BA0;
    w_m           = 8'h00;
    flg_m         = 3'h0;
    sys_rst_i     = 1'b1;
    instr_valid_i = 1'b0;
    instr_i       = 14'h0000;
    mem_rdata_i   = 8'hA5;
    repeat (5) @(posedge ref_clk_i);
    #DLY;
    sys_rst_i = 1'b0;
    check("rst_out", {w_o, flags_o, mem_re_o, mem_we_o, skip_o,
                      pc_load_o, port_a_data_reg_mismatch_clr_o}, 16'h0000);
    // boundaries of the address field, port A, both destinations
    file_op(OP_ADD, 1'b0, 7'h00, 8'h0F);
    file_op(OP_ADD, 1'b1, 7'h7F, 8'hF1);
    file_op(OP_AND, 1'b1, `FRRMW_PORT_A_DATA_REG_ADDR, 8'h3C);
    file_op(OP_ADD, 1'b0, `FRRMW_PORT_A_DATA_REG_ADDR, 8'hF1);
    file_op(OP_AND, 1'b0, 7'h7F, 8'h00);
    file_op(OP_ADD, 1'b0, 7'h04, 8'h80);
    file_op(OP_ADD, 1'b0, 7'h06, 8'h80);
    // random mix, values chosen across the full byte range
    repeat (60)
    begin
      rng = xorshift(rng);
      file_op(rng[0] ? OP_ADD : OP_AND, rng[1], rng[14:8], rng[23:16]);
    end
    // corners: clear of port A, both bit tests true, x bits set, far jump
    misc_op(14'h0185, 8'hFF);
    misc_op(14'h1F90, 8'h80);
    misc_op(14'h1810, 8'hFE);
    misc_op(14'h335A, 8'h00);
    misc_op(14'h2FFF, 8'h00);
    // random mix of the remaining operations
    repeat (40)
    begin
      rng = xorshift(rng);
      case (rng[2:0])
        3'h0: rnd_iw = {6'h01, 1'b1, rng[14:8]};
        3'h1: rnd_iw = {6'h00, 1'b1, rng[14:8]};
        3'h2: rnd_iw = {6'h08, rng[3], rng[14:8]};
        3'h3: rnd_iw = {4'hC, rng[5:4], rng[23:16]};
        3'h4: rnd_iw = {3'h5, rng[13:3]};
        default: rnd_iw = {2'h1, rng[4:3], rng[7:5], rng[14:8]};
      endcase
      misc_op(rnd_iw, rng[31:24]);
    end
    final_report();
  end
endmodule // tb_file_register_operand_decode_rmw
